// [src/lecs_map.svh]
// How it works
// - In mono emulation the display switches among text, half and full graphics from the two mode-control registers.
// - Mono text operation takes the row offset from the regular offset register.
// - Mono graphics operation takes the row offset from the alternate plus auxiliary offset registers.
// - Mono graphics operation takes horizontal timing from the alternate horizontal register set.
// - With emulation on and extensions off, host address bits 1 and 2 are ignored for timing controller access.
// - The timing controller block decodes at 3B0h-3B7h for mono or 3D0h-3D7h for colour addressing.
// - A trap is raised only for conditions whose enable bit is set in the trap enable register.
// - Traps come only from host I/O writes, never from reads or memory cycles.
// - In emulation the display address counter is captured at frame end just before it resets.
// - Reads of timing controller index 10h and 11h return the captured frame-end address.
// - Mono graphics ends active display two lines before the programmed vertical display end.
// - A write to a protected register completes normally but leaves the contents unchanged.
`ifndef LECS_MAP_SVH
`define LECS_MAP_SVH

// ========================================
// I/O addresses.
`define LECS_MONO_BASE      10'h03B0
`define LECS_COLOR_BASE     10'h03D0
`define LECS_MONO_MODE_ADR  10'h03B8
`define LECS_MONO_CFG_ADR   10'h03BF
`define LECS_COLOR_MODE_ADR 10'h03D8

// ========================================
// Timing controller indices.
`define LECS_IX_HTOTAL   8'h00
`define LECS_IX_HDEND    8'h01
`define LECS_IX_VDEND    8'h12
`define LECS_IX_OFFSET   8'h13
`define LECS_IX_FEA_HI   8'h10
`define LECS_IX_FEA_LO   8'h11
`define LECS_IX_ALT_HT   8'h20
`define LECS_IX_ALT_HDE  8'h21
`define LECS_IX_ALT_OFS  8'h22
`define LECS_IX_AUX_OFS  8'h23
`define LECS_IX_TRAP_EN  8'h24
`define LECS_IX_WPROT    8'h25

// ========================================
// Field positions.
`define LECS_MODE_GFX_BIT  1
`define LECS_CFG_HALF_BIT  0
`define LECS_CFG_FULL_BIT  1
`define LECS_WP_REG_BIT    0
`define LECS_WP_ALT_BIT    1
`define LECS_TRAP_MONO_BIT 0
`define LECS_TRAP_COL_BIT  1
`define LECS_TRAP_CRT_BIT  2

// ========================================
// Reset values and timing.
`define LECS_RST_BYTE    8'h00
`define LECS_GFX_VTRIM   11'h002

`endif

// [src/lecs_pkg.sv]
package lecs_pkg;
	typedef enum logic [1:0] {
		LECS_TEXT,
		LECS_HALF_GFX,
		LECS_FULL_GFX
	} lecs_disp_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [9:0] adr;
		logic [7:0] dat;
	} lecs_io_t;

	typedef struct packed {
		logic [7:0]  htotal;
		logic [7:0]  hdend;
		logic [10:0] vdend;
		logic [15:0] offset;
	} lecs_geom_t;
endpackage

// [src/lecs_byte_reg.sv]
`timescale 1ns/10ps
`include "lecs_map.svh"

// Byte register with select and protect gating.
module lecs_byte_reg (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       wr_en,
	input  wire logic       locked,
	input  wire logic [7:0] wr_dat,
	output logic      [7:0] val
);
	logic [7:0] val_q;
	logic [7:0] val_d;

	// A locked write is swallowed: the bus still finishes.
	always_comb begin
		val_d = val_q;
		if (wr_en && !locked) begin
			val_d = wr_dat;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			val_q <= `LECS_RST_BYTE;
		end else begin
			val_q <= val_d;
		end
	end

	assign val = val_q;

	property p_locked_hold;
		@(posedge core_clk) disable iff (sys_rst)
		wr_en && locked |=> val_q == $past(val_q);
	endproperty
	a_locked_hold: assert property (p_locked_hold)
		else $error("Protected byte changed.");
endmodule

// [src/lecs_mode_sel.sv]
`timescale 1ns/10ps
`include "lecs_map.svh"

// Chooses display kind and the active geometry set.
module lecs_mode_sel (
	input  wire logic                 mono_emul,
	input  wire logic [7:0]           mode_reg,
	input  wire logic [7:0]           cfg_reg,
	input  wire lecs_pkg::lecs_geom_t reg_set,
	input  wire lecs_pkg::lecs_geom_t alt_set,
	output lecs_pkg::lecs_disp_t      disp,
	output lecs_pkg::lecs_geom_t      geom
);
	logic gfx;

	// Graphics needs both the mode bit and a config permission.
	always_comb begin
		gfx  = mono_emul && mode_reg[`LECS_MODE_GFX_BIT]
		       && (cfg_reg[`LECS_CFG_HALF_BIT]
		       || cfg_reg[`LECS_CFG_FULL_BIT]);
		disp = lecs_pkg::LECS_TEXT;
		if (gfx) begin
			disp = cfg_reg[`LECS_CFG_FULL_BIT] ? lecs_pkg::LECS_FULL_GFX
			       : lecs_pkg::LECS_HALF_GFX;
		end
		geom = reg_set;
		if (gfx) begin
			geom.htotal = alt_set.htotal;
			geom.hdend  = alt_set.hdend;
			geom.offset = alt_set.offset;
			geom.vdend  = reg_set.vdend - `LECS_GFX_VTRIM;
		end
	end
endmodule

// [src/lecs_top.sv]
`timescale 1ns/10ps
`include "lecs_map.svh"

// Emulation front end: I/O decode, register sets, traps, frame capture.
module lecs_top (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        io_wr_n,
	input  wire logic        io_rd_n,
	input  wire logic        mem_cyc,
	input  wire logic [9:0]  io_adr,
	input  wire logic [7:0]  io_wdat,
	input  wire logic        emul_en,
	input  wire logic        mono_emul,
	input  wire logic        ext_en,
	input  wire logic        frame_end,
	input  wire logic [15:0] disp_addr,
	output logic      [7:0]  io_rdat,
	output logic             io_rdat_oe,
	output logic             trap_n,
	output lecs_pkg::lecs_disp_t disp_mode,
	output lecs_pkg::lecs_geom_t geom
);
	// ========================================
	// Pin synchronisers and registered state.
	typedef struct packed {
		logic [1:0] wr_n;
		logic [1:0] rd_n;
		logic       wr_n_old;
		logic       rd_n_old;
		logic [7:0] index;
		logic [15:0] fea;
		logic [7:0] rdat;
		logic       rdat_oe;
		logic       trap;
		logic [9:0] adr_m;
		logic [9:0] adr_s;
		logic [7:0] wdat_m;
		logic [7:0] wdat_s;
		logic       mem_m;
		logic       mem_s;
	} lecs_state_t;

	lecs_state_t s_q;
	lecs_state_t s_d;

	logic        wr_pulse;
	logic        rd_pulse;
	logic        rd_act;
	logic        mono_hit;
	logic        col_hit;
	logic        crt_hit;
	logic [2:0]  crt_off;
	logic        idx_wr;
	logic        dat_wr;
	logic [7:0]  wr_sel;
	logic [7:0]  v_htot;
	logic [7:0]  v_hde;
	logic [7:0]  v_vde;
	logic [7:0]  v_ofs;
	logic [7:0]  v_aht;
	logic [7:0]  v_ahde;
	logic [7:0]  v_aofs;
	logic [7:0]  v_auxo;
	logic [7:0]  v_trap;
	logic [7:0]  v_wp;
	logic [7:0]  v_mode;
	logic [7:0]  v_cfg;
	logic        trap_hit;
	lecs_pkg::lecs_geom_t reg_set;
	lecs_pkg::lecs_geom_t alt_set;
	logic [9:0]  adr;
	logic [7:0]  wdat;
	logic        mem;

	// Block bases as vectors so the compare takes just the upper bits.
	localparam logic [9:0] mono_base  = `LECS_MONO_BASE;
	localparam logic [9:0] color_base = `LECS_COLOR_BASE;

	// ========================================
	// Address decode.
	// Mono or colour block, with aliasing when extensions are hidden.
	always_comb begin
		mono_hit = adr[9:3] == mono_base[9:3];
		col_hit  = adr[9:3] == color_base[9:3];
		crt_hit  = mono_emul ? mono_hit : col_hit;
		crt_off  = adr[2:0];
		if (emul_en && !ext_en) begin
			crt_off[2:1] = 2'b10;
		end
	end

	// Address, data and cycle kind come from the second sync stage, so
	// they are exactly as old as the strobe that qualifies them.
	assign adr  = s_q.adr_s;
	assign wdat = s_q.wdat_s;
	assign mem  = s_q.mem_s;

	// Only the settled falling edge of the write strobe counts.
	assign wr_pulse = !s_q.wr_n[1] && s_q.wr_n_old;
	assign rd_pulse = !s_q.rd_n[1] && s_q.rd_n_old;
	assign rd_act   = !s_q.rd_n[1];
	assign idx_wr   = wr_pulse && crt_hit && crt_off == 3'd4;
	assign dat_wr   = wr_pulse && crt_hit && crt_off == 3'd5;

	// ========================================
	// Register file.
	// One-hot write select per stored index.
	always_comb begin
		wr_sel    = 8'h00;
		wr_sel[0] = dat_wr && s_q.index == `LECS_IX_HTOTAL;
		wr_sel[1] = dat_wr && s_q.index == `LECS_IX_HDEND;
		wr_sel[2] = dat_wr && s_q.index == `LECS_IX_VDEND;
		wr_sel[3] = dat_wr && s_q.index == `LECS_IX_OFFSET;
		wr_sel[4] = dat_wr && s_q.index == `LECS_IX_ALT_HT;
		wr_sel[5] = dat_wr && s_q.index == `LECS_IX_ALT_HDE;
		wr_sel[6] = dat_wr && s_q.index == `LECS_IX_ALT_OFS;
		wr_sel[7] = dat_wr && s_q.index == `LECS_IX_AUX_OFS;
	end

	lecs_byte_reg u_htot (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[0]), .locked(v_wp[`LECS_WP_REG_BIT]),
		.wr_dat(wdat), .val(v_htot));
	lecs_byte_reg u_hde (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[1]), .locked(v_wp[`LECS_WP_REG_BIT]),
		.wr_dat(wdat), .val(v_hde));
	lecs_byte_reg u_vde (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[2]), .locked(v_wp[`LECS_WP_REG_BIT]),
		.wr_dat(wdat), .val(v_vde));
	lecs_byte_reg u_ofs (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[3]), .locked(v_wp[`LECS_WP_REG_BIT]),
		.wr_dat(wdat), .val(v_ofs));
	lecs_byte_reg u_aht (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[4]), .locked(v_wp[`LECS_WP_ALT_BIT]),
		.wr_dat(wdat), .val(v_aht));
	lecs_byte_reg u_ahde (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[5]), .locked(v_wp[`LECS_WP_ALT_BIT]),
		.wr_dat(wdat), .val(v_ahde));
	lecs_byte_reg u_aofs (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[6]), .locked(v_wp[`LECS_WP_ALT_BIT]),
		.wr_dat(wdat), .val(v_aofs));
	lecs_byte_reg u_auxo (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_sel[7]), .locked(v_wp[`LECS_WP_ALT_BIT]),
		.wr_dat(wdat), .val(v_auxo));

	// Trap enables and protect bits are never locked themselves.
	lecs_byte_reg u_trap (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(dat_wr && s_q.index == `LECS_IX_TRAP_EN), .locked(1'b0),
		.wr_dat(wdat), .val(v_trap));
	lecs_byte_reg u_wp (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(dat_wr && s_q.index == `LECS_IX_WPROT), .locked(1'b0),
		.wr_dat(wdat), .val(v_wp));
	lecs_byte_reg u_mode (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_pulse && adr == `LECS_MONO_MODE_ADR),
		.locked(1'b0), .wr_dat(wdat), .val(v_mode));
	lecs_byte_reg u_cfg (.core_clk(core_clk), .sys_rst(sys_rst),
		.wr_en(wr_pulse && adr == `LECS_MONO_CFG_ADR),
		.locked(1'b0), .wr_dat(wdat), .val(v_cfg));

	// ========================================
	// Geometry selection.
	always_comb begin
		reg_set.htotal = v_htot;
		reg_set.hdend  = v_hde;
		reg_set.vdend  = {1'b0, v_vde, 2'b00};
		reg_set.offset = {8'h00, v_ofs};
		alt_set.htotal = v_aht;
		alt_set.hdend  = v_ahde;
		alt_set.vdend  = reg_set.vdend;
		alt_set.offset = {v_auxo, v_aofs};
	end

	lecs_mode_sel u_sel (
		.mono_emul(mono_emul),
		.mode_reg (v_mode),
		.cfg_reg  (v_cfg),
		.reg_set  (reg_set),
		.alt_set  (alt_set),
		.disp     (disp_mode),
		.geom     (geom)
	);

	// ========================================
	// Traps.
	// Reads and memory cycles can never trap. The colour mode port lies
	// just above the colour block, so it is matched on its own address.
	always_comb begin
		trap_hit = wr_pulse && !mem && (
		           (v_trap[`LECS_TRAP_MONO_BIT] && mono_hit) ||
		           (v_trap[`LECS_TRAP_COL_BIT] && col_hit) ||
		           (v_trap[`LECS_TRAP_CRT_BIT] &&
		            adr == `LECS_COLOR_MODE_ADR));
	end

	// ========================================
	// State update.
	always_comb begin
		s_d          = s_q;
		s_d.wr_n     = {s_q.wr_n[0], io_wr_n};
		s_d.rd_n     = {s_q.rd_n[0], io_rd_n};
		s_d.wr_n_old = s_q.wr_n[1];
		s_d.rd_n_old = s_q.rd_n[1];
		s_d.adr_m    = io_adr;
		s_d.adr_s    = s_q.adr_m;
		s_d.wdat_m   = io_wdat;
		s_d.wdat_s   = s_q.wdat_m;
		s_d.mem_m    = mem_cyc;
		s_d.mem_s    = s_q.mem_m;
		s_d.trap     = trap_hit;
		if (idx_wr) begin
			s_d.index = wdat;
		end
		// Capture on the frame-end strobe, before the counter clears.
		if (frame_end && emul_en) begin
			s_d.fea = disp_addr;
		end
		s_d.rdat_oe = rd_act && crt_hit;
		if (rd_pulse && crt_hit && crt_off == 3'd5) begin
			s_d.rdat = 8'h00;
			if (s_q.index == `LECS_IX_FEA_HI) begin
				s_d.rdat = s_q.fea[15:8];
			end else if (s_q.index == `LECS_IX_FEA_LO) begin
				s_d.rdat = s_q.fea[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{wr_n: 2'b11, rd_n: 2'b11, wr_n_old: 1'b1,
			         rd_n_old: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign io_rdat    = s_q.rdat;
	assign io_rdat_oe = s_q.rdat_oe;
	assign trap_n     = !s_q.trap;

	// ========================================
	// Checks.
	property p_no_trap_read;
		@(posedge core_clk) disable iff (sys_rst)
		!wr_pulse |=> !s_q.trap;
	endproperty
	a_no_trap_read: assert property (p_no_trap_read)
		else $error("Trap without a write.");

	property p_trap_masked;
		@(posedge core_clk) disable iff (sys_rst)
		v_trap == 8'h00 |=> trap_n;
	endproperty
	a_trap_masked: assert property (p_trap_masked)
		else $error("Trap with all enables clear.");

	property p_capture;
		@(posedge core_clk) disable iff (sys_rst)
		frame_end && emul_en |=> s_q.fea == $past(disp_addr);
	endproperty
	a_capture: assert property (p_capture)
		else $error("Frame-end address not captured.");

	property p_gfx_offset;
		@(posedge core_clk) disable iff (sys_rst)
		disp_mode != lecs_pkg::LECS_TEXT |-> geom.offset == {v_auxo, v_aofs};
	endproperty
	a_gfx_offset: assert property (p_gfx_offset)
		else $error("Graphics offset wrong.");

	property p_text_offset;
		@(posedge core_clk) disable iff (sys_rst)
		disp_mode == lecs_pkg::LECS_TEXT |-> geom.offset == {8'h00, v_ofs};
	endproperty
	a_text_offset: assert property (p_text_offset)
		else $error("Text offset wrong.");

	property p_gfx_horiz;
		@(posedge core_clk) disable iff (sys_rst)
		disp_mode != lecs_pkg::LECS_TEXT |-> geom.htotal == v_aht;
	endproperty
	a_gfx_horiz: assert property (p_gfx_horiz)
		else $error("Graphics horizontal set wrong.");

	property p_vtrim;
		@(posedge core_clk) disable iff (sys_rst)
		disp_mode != lecs_pkg::LECS_TEXT |->
			geom.vdend == reg_set.vdend - 11'd2;
	endproperty
	a_vtrim: assert property (p_vtrim)
		else $error("Graphics vertical end not trimmed.");

	property p_mode_sel;
		@(posedge core_clk) disable iff (sys_rst)
		!mono_emul |-> disp_mode == lecs_pkg::LECS_TEXT;
	endproperty
	a_mode_sel: assert property (p_mode_sel)
		else $error("Graphics outside mono emulation.");

	property p_read_hi;
		@(posedge core_clk) disable iff (sys_rst)
		rd_pulse && crt_hit && crt_off == 3'd5 &&
		s_q.index == `LECS_IX_FEA_HI |=> io_rdat == $past(s_q.fea[15:8]);
	endproperty
	a_read_hi: assert property (p_read_hi)
		else $error("High capture byte not returned.");

	property p_alias;
		@(posedge core_clk) disable iff (sys_rst)
		emul_en && !ext_en |-> crt_off[2:1] == 2'b10;
	endproperty
	a_alias: assert property (p_alias)
		else $error("Alias bits not ignored.");

	property p_decode;
		@(posedge core_clk) disable iff (sys_rst)
		crt_hit |-> adr[9:3] == (mono_emul ? 7'h76 : 7'h7A);
	endproperty
	a_decode: assert property (p_decode)
		else $error("Block decoded outside its range.");

	// An I/O write that lands in the mono block.
	sequence s_mono_wr;
		wr_pulse && !mem && mono_hit;
	endsequence

	property p_trap_mono;
		@(posedge core_clk) disable iff (sys_rst)
		s_mono_wr ##0 v_trap[`LECS_TRAP_MONO_BIT] |=> !trap_n;
	endproperty
	a_trap_mono: assert property (p_trap_mono)
		else $error("Enabled trap not raised.");
endmodule

// [verif/lecs_host.sv]
`timescale 1ns/10ps

// ========================================
// Host model: drives the I/O strobes and counts trap pulses.
module lecs_host (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       trap_n,
	input  wire logic [7:0] io_rdat,
	input  wire logic       io_rdat_oe,
	output logic            io_wr_n,
	output logic            io_rd_n,
	output logic            mem_cyc,
	output logic      [9:0] io_adr,
	output logic      [7:0] io_wdat
);
	int trap_cnt = 0;

	// Each low cycle of trap_n is one trap pulse.
	always @(posedge core_clk) begin
		if (!sys_rst && trap_n === 1'b0) begin
			trap_cnt <= trap_cnt + 1;
		end
	end

	// Idle bus at time zero.
	initial begin
		io_wr_n = 1'b1;
		io_rd_n = 1'b1;
		mem_cyc = 1'b0;
		io_adr  = 10'h000;
		io_wdat = 8'h00;
	end

	// Once hold time is over the lines show junk, not the old value.
	task automatic float_bus();
		io_adr  = ~io_adr;
		io_wdat = ~io_wdat;
		mem_cyc = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask

	// Strobe held five cycles so the two-flop sync surely sees it.
	task automatic wr(input logic [9:0] a, input logic [7:0] d,
		input logic mem);
		@(negedge core_clk);
		io_adr  = a;
		io_wdat = d;
		mem_cyc = mem;
		io_wr_n = 1'b0;
		repeat (5) @(negedge core_clk);
		io_wr_n = 1'b1;
		@(negedge core_clk);
		float_bus();
	endtask

	// Read data is taken while the strobe is still low.
	task automatic rd(input logic [9:0] a, output logic [7:0] d,
		output logic oe);
		@(negedge core_clk);
		io_adr  = a;
		io_rd_n = 1'b0;
		repeat (5) @(negedge core_clk);
		d       = io_rdat;
		oe      = io_rdat_oe;
		io_rd_n = 1'b1;
		@(negedge core_clk);
		float_bus();
	endtask
endmodule

// [verif/legacy_emulation_crt_timing_controller_select_tb.sv]
`timescale 1ns/10ps
`include "lecs_map.svh"

module legacy_emulation_crt_timing_controller_select_tb;
	typedef struct packed {
		logic [7:0]           mode;
		logic [7:0]           cfg;
		lecs_pkg::lecs_disp_t disp;
		logic                 gfx;
	} lecs_row_t;

	localparam logic [9:0] mb = `LECS_MONO_BASE;
	localparam logic [9:0] cb = `LECS_COLOR_BASE;
	logic                 core_clk = 1'b0;
	logic                 sys_rst;
	logic                 io_wr_n;
	logic                 io_rd_n;
	logic                 mem_cyc;
	logic [9:0]           io_adr;
	logic [7:0]           io_wdat;
	logic                 emul_en;
	logic                 mono_emul;
	logic                 ext_en;
	logic                 frame_end;
	logic [15:0]          disp_addr;
	logic [7:0]           io_rdat;
	logic                 io_rdat_oe;
	logic                 trap_n;
	lecs_pkg::lecs_disp_t disp_mode;
	lecs_pkg::lecs_geom_t geom;
	int                   error_cnt = 0;
	int                   n_compared = 0;
	int                   cyc_cnt = 0;
	lecs_row_t            rows [4];

	// ========================================
	// Clock and instances.
	always #12.5 core_clk = ~core_clk;

	lecs_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .mem_cyc(mem_cyc),
		.io_adr(io_adr), .io_wdat(io_wdat), .emul_en(emul_en),
		.mono_emul(mono_emul), .ext_en(ext_en), .frame_end(frame_end),
		.disp_addr(disp_addr), .io_rdat(io_rdat),
		.io_rdat_oe(io_rdat_oe), .trap_n(trap_n),
		.disp_mode(disp_mode), .geom(geom));

	lecs_host host (.core_clk(core_clk), .sys_rst(sys_rst),
		.trap_n(trap_n), .io_rdat(io_rdat), .io_rdat_oe(io_rdat_oe),
		.io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .mem_cyc(mem_cyc),
		.io_adr(io_adr), .io_wdat(io_wdat));

	// ========================================
	// Checks and helpers.
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_mode(input lecs_pkg::lecs_disp_t e);
		n_compared++;
		if (disp_mode !== e) begin
			error_cnt++;
			$display("ERROR disp_mode expected %0d seen %0d", e, disp_mode);
		end
	endtask

	task automatic crt(input logic [9:0] b, input logic [7:0] ix,
		input logic [7:0] v);
		host.wr(b + 10'h004, ix, 1'b0);
		host.wr(b + 10'h005, v, 1'b0);
	endtask

	task automatic crt_rd(input logic [9:0] b, input logic [7:0] ix,
		input logic [7:0] e);
		logic [7:0] d;
		logic       oe;
		host.wr(b + 10'h004, ix, 1'b0);
		host.rd(b + 10'h005, d, oe);
		chk("read data", {8'h00, e}, {8'h00, d});
		chk("read enable", 16'h0001, {15'h0000, oe});
	endtask

	// Counts traps caused by one single write.
	task automatic trap_wr(input logic [9:0] a, input logic mem,
		input int e);
		int t0;
		t0 = host.trap_cnt;
		host.wr(a, 8'h00, mem);
		chk("trap count", 16'(e), 16'(host.trap_cnt - t0));
	endtask

	// The frame-end pulse captures; later counter moves must not.
	task automatic capture(input logic [9:0] b, input logic [15:0] v);
		@(negedge core_clk);
		disp_addr = v;
		frame_end = 1'b1;
		@(negedge core_clk);
		frame_end = 1'b0;
		disp_addr = ~v;
		crt_rd(b, `LECS_IX_FEA_HI, v[15:8]);
		crt_rd(b, `LECS_IX_FEA_LO, v[7:0]);
	endtask

	// Bounded run; a hang counts as a mismatch.
	always @(posedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 8000) begin
			error_cnt++;
			final_report();
		end
	end

	// ========================================
	// Main sequence.
	initial begin
		rows[0] = '{8'h00, 8'h00, lecs_pkg::LECS_TEXT, 1'b0};
		rows[1] = '{8'h02, 8'h01, lecs_pkg::LECS_HALF_GFX, 1'b1};
		rows[2] = '{8'h02, 8'h02, lecs_pkg::LECS_FULL_GFX, 1'b1};
		rows[3] = '{8'h00, 8'h03, lecs_pkg::LECS_TEXT, 1'b0};
		sys_rst   = 1'b1;
		emul_en   = 1'b1;
		mono_emul = 1'b1;
		ext_en    = 1'b1;
		frame_end = 1'b0;
		disp_addr = 16'h0000;
		repeat (8) @(negedge core_clk);
		chk("rst rdat", 16'h0000, {8'h00, io_rdat});
		chk("rst oe", 16'h0000, {15'h0000, io_rdat_oe});
		chk("rst trap", 16'h0001, {15'h0000, trap_n});
		chk_mode(lecs_pkg::LECS_TEXT);
		sys_rst = 1'b0;
		crt(mb, `LECS_IX_HTOTAL, 8'h5F);
		crt(mb, `LECS_IX_HDEND, 8'h4F);
		crt(mb, `LECS_IX_VDEND, 8'h57);
		crt(mb, `LECS_IX_OFFSET, 8'h28);
		crt(mb, `LECS_IX_ALT_HT, 8'h38);
		crt(mb, `LECS_IX_ALT_HDE, 8'h2D);
		crt(mb, `LECS_IX_ALT_OFS, 8'h16);
		crt(mb, `LECS_IX_AUX_OFS, 8'h01);
		// Every display kind, and the geometry set it selects.
		foreach (rows[i]) begin
			host.wr(`LECS_MONO_MODE_ADR, rows[i].mode, 1'b0);
			host.wr(`LECS_MONO_CFG_ADR, rows[i].cfg, 1'b0);
			chk_mode(rows[i].disp);
			chk("htotal", rows[i].gfx ? 16'h0038 : 16'h005F, 16'(geom.htotal));
			chk("hdend", rows[i].gfx ? 16'h002D : 16'h004F, 16'(geom.hdend));
			chk("offset", rows[i].gfx ? 16'h0116 : 16'h0028, geom.offset);
			chk("vdend", rows[i].gfx ? 16'h015A : 16'h015C, 16'(geom.vdend));
		end
		// Aliased addresses with extensions off; now in text mode.
		ext_en = 1'b0;
		host.wr(mb + 10'h002, `LECS_IX_HTOTAL, 1'b0);
		host.wr(mb + 10'h003, 8'h71, 1'b0);
		chk("alias htotal", 16'h0071, 16'(geom.htotal));
		ext_en = 1'b1;
		// Protected regular set keeps its value; the alternate set does not.
		crt(mb, `LECS_IX_WPROT, 8'h01);
		crt(mb, `LECS_IX_HTOTAL, 8'hAA);
		chk("protected htotal", 16'h0071, 16'(geom.htotal));
		host.wr(`LECS_MONO_MODE_ADR, 8'h02, 1'b0);
		crt(mb, `LECS_IX_ALT_HT, 8'hBB);
		chk("open alt htotal", 16'h00BB, 16'(geom.htotal));
		crt(mb, `LECS_IX_WPROT, 8'h00);
		host.wr(`LECS_MONO_MODE_ADR, 8'h00, 1'b0);
		// Colour addressing decodes at its own base.
		mono_emul = 1'b0;
		crt(cb, `LECS_IX_OFFSET, 8'h44);
		chk("colour offset", 16'h0044, 16'(geom.offset[7:0]));
		capture(cb, 16'hABCD);
		mono_emul = 1'b1;
		capture(mb, 16'h1234);
		// Traps follow the enable bits and only I/O writes.
		crt(mb, `LECS_IX_TRAP_EN, 8'h01);
		trap_wr(mb + 10'h004, 1'b0, 1);
		trap_wr(mb + 10'h004, 1'b1, 0);
		trap_wr(cb + 10'h004, 1'b0, 0);
		trap_wr(`LECS_COLOR_MODE_ADR, 1'b0, 0);
		begin : rd_no_trap
			int         t0;
			logic [7:0] d;
			logic       oe;
			host.wr(mb + 10'h004, `LECS_IX_FEA_LO, 1'b0);
			t0 = host.trap_cnt;
			host.rd(mb + 10'h005, d, oe);
			chk("read trap", 16'h0000, 16'(host.trap_cnt - t0));
			chk("read low", 16'h0034, {8'h00, d});
		end
		crt(mb, `LECS_IX_TRAP_EN, 8'h04);
		trap_wr(`LECS_COLOR_MODE_ADR, 1'b0, 1);
		trap_wr(mb + 10'h004, 1'b0, 0);
		// A reset in mid-run clears the sets; the next write must land.
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		chk("rerun htotal", 16'h0000, 16'(geom.htotal));
		chk("rerun trap", 16'h0001, {15'h0000, trap_n});
		chk_mode(lecs_pkg::LECS_TEXT);
		crt(mb, `LECS_IX_HTOTAL, 8'h33);
		chk("after reset htotal", 16'h0033, 16'(geom.htotal));
		final_report();
	end
endmodule
